// ---- hdl/sr_mrr_device.sv ----
// self refresh, partial array masking and mode register read logic
//
// How it works
// - sre taken with cke fall, cs low, ca=100
// - receivers stay on for two cycles after entry
// - self refresh ignores all but cke, timer refreshes
// - entry starts an all-bank sweep at once
// - exit interval counts from edge after cke high
// - masked bank gets no self refresh
// - masked segment skipped in unmasked banks
// - one means masked, bank and segment combine
// - reserved mask register writes do nothing
// - mrr decoded, address from fall and rise ca
// - others read zero, first beat low byte; calib pattern every beat
// - all strobes toggle through the read burst
// - read burst is eight beats, never cut
// - self refresh exit zeroes per-bank pointer
`timescale 1ns/1ps
module sr_mrr_device (
  // core clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  // link clock and command pins
  input  wire logic                     ck_in,
  input  wire sr_mrr_pkg::cmd_t         cmd_in,
  // data pins
  input  wire logic [31:0]              dq_in,
  input  wire logic [3:0]               dqs_in,
  output sr_mrr_pkg::data_bus_t         data_out,
  // link status
  output logic                          receivers_on_out,
  output logic [2:0]                    bank_ptr_out,
  // internal refresh engine
  output logic                          self_refresh_out,
  output sr_mrr_pkg::refresh_t          refresh_out
);
  import sr_mrr_pkg::*;

  // ---------------------------------------------------------------
  // state of the link side
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              rst_s1;
    logic              rst_s2;
    link_fsm_t         fsm;
    logic              cke_prev;
    logic [LCNT_W-1:0] cnt;
    logic              sr_level;
    logic              rx_on;
    logic [2:0]        bank_ptr;
    logic [7:0]        bank_mask;
    logic [7:0]        seg_mask;
    logic [LCNT_W-1:0] lat;
    logic              burst_on;
    logic [2:0]        beat;
    logic [7:0]        mr_addr;
    data_bus_t         bus;
  } link_state_t;

  // ---------------------------------------------------------------
  // state of the core side
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             sr_s1;
    logic             sr_s2;
    logic             sr_prev;
    core_fsm_t        fsm;
    logic [7:0]       bank_mask;
    logic [7:0]       seg_mask;
    logic [2:0]       bank_idx;
    logic [2:0]       seg;
    logic [ROW_W-1:0] row;
    logic [GAP_W-1:0] gap;
    refresh_t         ref_q;
  } core_state_t;

  link_state_t lk_q;
  link_state_t lk_d;
  core_state_t cr_q;
  core_state_t cr_d;

  logic       lk_active;
  logic       lk_busy;
  logic       is_sre;
  logic       is_ref;
  logic       is_mrr;
  logic       is_mrw;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;

  // ---------------------------------------------------------------
  // read burst beat contents
  // ---------------------------------------------------------------
  function automatic data_bus_t beat_word(
    input logic [7:0] addr,
    input logic [2:0] beat
  );
    data_bus_t w;
    w        = '0;
    w.dq_oe  = 1'b1;
    w.dqs_oe = 1'b1;
    w.dqs    = {DQS_W{~beat[0]}};
    if (addr == MR_CALIB_A) begin
      w.dq = {DQ_W{PATTERN_A[beat]}};
    end else if (addr == MR_CALIB_B) begin
      w.dq = {DQ_W{PATTERN_B[beat]}};
    end else if (beat == 3'h0) begin
      w.dq = {24'h000000, MR_READ_ZERO};
    end
    return w;
  endfunction

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  assign cmd_addr  = {cmd_in.ca_rise[9:4], cmd_in.ca_fall[1:0]};
  assign cmd_data  = cmd_in.ca_fall[9:2];
  assign lk_active = cmd_in.cke && lk_q.cke_prev && !cmd_in.cs_n;
  assign lk_busy   = (lk_q.lat != '0) || lk_q.burst_on;

  always_comb begin
    is_sre = lk_q.cke_prev && !cmd_in.cke && !cmd_in.cs_n &&
             (cmd_in.ca_rise[2:0] == CMD_REF_SRE);
    is_ref = lk_active && (cmd_in.ca_rise[2:0] == CMD_REF_SRE);
    is_mrr = lk_active && (cmd_in.ca_rise[3:0] == CMD_MRR);
    is_mrw = lk_active && (cmd_in.ca_rise[3:0] == CMD_MRW);
  end

  // ---------------------------------------------------------------
  // link side next state
  // ---------------------------------------------------------------
  always_comb begin
    lk_d          = lk_q;
    lk_d.rst_s1   = reset_in;
    lk_d.rst_s2   = lk_q.rst_s1;
    lk_d.cke_prev = cmd_in.cke;

    // read burst runs to its end whatever arrives
    if (lk_q.lat != '0) begin
      lk_d.lat = lk_q.lat - CNT_ONE;
      if (lk_q.lat == CNT_ONE) begin
        lk_d.burst_on = 1'b1;
        lk_d.beat     = 3'h0;
        lk_d.bus      = beat_word(lk_q.mr_addr, 3'h0);
      end
    end else if (lk_q.burst_on) begin
      if (lk_q.beat == LAST_BEAT) begin
        lk_d.burst_on = 1'b0;
        lk_d.bus      = '0;
      end else begin
        lk_d.beat = lk_q.beat + 3'h1;
        lk_d.bus  = beat_word(lk_q.mr_addr, lk_q.beat + 3'h1);
      end
    end

    case (lk_q.fsm)
      LK_IDLE: begin
        if (is_sre && !lk_busy) begin
          lk_d.fsm      = LK_CPDED;
          lk_d.cnt      = CPDED_CNT;
          lk_d.sr_level = 1'b1;
        end else if (is_mrr && !lk_busy) begin
          lk_d.lat     = RL_CNT;
          lk_d.mr_addr = cmd_addr;
        end else if (is_mrw && !lk_busy) begin
          if (cmd_addr == MR_BANK_MASK) begin
            lk_d.bank_mask = cmd_data;
          end else if (cmd_addr == MR_SEG_MASK) begin
            lk_d.seg_mask = cmd_data;
          end
          // other addresses, reserved one included, are dropped
        end else if (is_ref) begin
          if (cmd_in.ca_rise[3]) begin
            lk_d.bank_ptr = 3'h0;
          end else begin
            lk_d.bank_ptr = lk_q.bank_ptr + 3'h1;
          end
        end
      end
      LK_CPDED: begin
        lk_d.cnt = lk_q.cnt - CNT_ONE;
        if (lk_q.cnt == CNT_ONE) begin
          lk_d.fsm   = LK_SELF;
          lk_d.rx_on = 1'b0;
        end
      end
      LK_SELF: begin
        // only cke is looked at here
        if (cmd_in.cke) begin
          lk_d.fsm      = LK_EXIT;
          lk_d.cnt      = TXSR_CNT;
          lk_d.rx_on    = 1'b1;
          lk_d.sr_level = 1'b0;
          lk_d.bank_ptr = 3'h0;
        end
      end
      LK_EXIT: begin
        lk_d.cnt = lk_q.cnt - CNT_ONE;
        if (lk_q.cnt == CNT_ONE) begin
          lk_d.fsm = LK_IDLE;
        end
      end
      default: begin
        lk_d.fsm = LK_IDLE;
      end
    endcase

    if (lk_q.rst_s2) begin
      lk_d          = '0;
      lk_d.rst_s1   = reset_in;
      lk_d.rst_s2   = lk_q.rst_s1;
      lk_d.rx_on    = 1'b1;
      lk_d.cke_prev = cmd_in.cke;
    end
  end

  always_ff @(posedge ck_in) begin
    lk_q <= lk_d;
  end

  // ---------------------------------------------------------------
  // core side next state: internal refresh timer
  // ---------------------------------------------------------------
  always_comb begin
    cr_d             = cr_q;
    cr_d.sr_s1       = lk_q.sr_level;
    cr_d.sr_s2       = cr_q.sr_s1;
    cr_d.sr_prev     = cr_q.sr_s2;
    cr_d.ref_q.valid = 1'b0;

    case (cr_q.fsm)
      CR_IDLE: begin
        if (cr_q.sr_s2 && !cr_q.sr_prev) begin
          // masks are still since the link went into self refresh
          cr_d.bank_mask = lk_q.bank_mask;
          cr_d.seg_mask  = lk_q.seg_mask;
          cr_d.bank_idx  = 3'h0;
          cr_d.fsm       = CR_SWEEP;
        end
      end
      CR_SWEEP: begin
        if (!cr_q.sr_s2) begin
          cr_d.fsm = CR_IDLE;
        end else begin
          if (!cr_q.bank_mask[cr_q.bank_idx] &&
              !cr_q.seg_mask[cr_q.seg]) begin
            cr_d.ref_q.valid   = 1'b1;
            cr_d.ref_q.bank    = cr_q.bank_idx;
            cr_d.ref_q.segment = cr_q.seg;
            cr_d.ref_q.row     = cr_q.row;
          end
          cr_d.bank_idx = cr_q.bank_idx + 3'h1;
          if (cr_q.bank_idx == LAST_BANK) begin
            cr_d.row = cr_q.row + ROW_W'(1);
            if (&cr_q.row) begin
              cr_d.seg = cr_q.seg + 3'h1;
            end
            cr_d.gap = REF_GAP_CNT;
            cr_d.fsm = CR_WAIT;
          end
        end
      end
      CR_WAIT: begin
        if (!cr_q.sr_s2) begin
          cr_d.fsm = CR_IDLE;
        end else if (cr_q.gap == GAP_ONE) begin
          cr_d.fsm = CR_SWEEP;
        end else begin
          cr_d.gap = cr_q.gap - GAP_ONE;
        end
      end
      default: begin
        cr_d.fsm = CR_IDLE;
      end
    endcase

    if (reset_in) begin
      cr_d = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    cr_q <= cr_d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign data_out         = lk_q.bus;
  assign receivers_on_out = lk_q.rx_on;
  assign bank_ptr_out     = lk_q.bank_ptr;
  assign self_refresh_out = cr_q.sr_s2;
  assign refresh_out      = cr_q.ref_q;

endmodule

// ---- hdl/sr_mrr_pkg.sv ----
// constants, command codes and carrier types of the self refresh block
package sr_mrr_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CA_W   = 10;
  localparam int DQ_W   = 32;
  localparam int DQS_W  = 4;
  localparam int ROW_W  = 10;
  localparam int LCNT_W = 4;
  localparam int GAP_W  = 12;

  // ---------------------------------------------------------------
  // mode register addresses and values
  // ---------------------------------------------------------------
  localparam logic [7:0] MR_BANK_MASK = 8'h10;
  localparam logic [7:0] MR_SEG_MASK  = 8'h11;
  localparam logic [7:0] MR_CALIB_A   = 8'h20;
  localparam logic [7:0] MR_CALIB_B   = 8'h28;
  localparam logic [7:0] PATTERN_A    = 8'h55;
  localparam logic [7:0] PATTERN_B    = 8'hcc;
  localparam logic [7:0] MR_READ_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // command codes on the rising half of the ca bus
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_REF_SRE = 3'h4;
  localparam logic [3:0] CMD_MRR     = 4'h8;
  localparam logic [3:0] CMD_MRW     = 4'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CK_PERIOD_NS   = 160;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TXSR_NS        = 200;
  localparam int TXSR_CYC       =
    (TXSR_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
  localparam int REF_GAP_NS     = 1000;
  localparam int REF_GAP_CYC    = REF_GAP_NS / CLK_PERIOD_NS;
  localparam logic [LCNT_W-1:0] TXSR_CNT    = LCNT_W'(TXSR_CYC);
  localparam logic [LCNT_W-1:0] CPDED_CNT   = 4'h2;
  localparam logic [LCNT_W-1:0] RL_CNT      = 4'h8;
  localparam logic [LCNT_W-1:0] CNT_ONE     = 4'h1;
  localparam logic [2:0]        LAST_BEAT   = 3'h7;
  localparam logic [2:0]        LAST_BANK   = 3'h7;
  localparam logic [GAP_W-1:0]  REF_GAP_CNT = GAP_W'(REF_GAP_CYC);
  localparam logic [GAP_W-1:0]  GAP_ONE     = 12'h001;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LK_IDLE  = 2'b00,
    LK_CPDED = 2'b01,
    LK_SELF  = 2'b10,
    LK_EXIT  = 2'b11
  } link_fsm_t;

  typedef enum logic [1:0] {
    CR_IDLE  = 2'b00,
    CR_SWEEP = 2'b01,
    CR_WAIT  = 2'b10
  } core_fsm_t;

  typedef struct packed {
    logic            cke;
    logic            cs_n;
    logic [CA_W-1:0] ca_rise;
    logic [CA_W-1:0] ca_fall;
  } cmd_t;

  typedef struct packed {
    logic [DQ_W-1:0]  dq;
    logic             dq_oe;
    logic [DQS_W-1:0] dqs;
    logic             dqs_oe;
  } data_bus_t;

  typedef struct packed {
    logic             valid;
    logic [2:0]       bank;
    logic [2:0]       segment;
    logic [ROW_W-1:0] row;
  } refresh_t;

endpackage

// ---- tb/ctrl_model.sv ----
// controller model driving the link clock and the command pins
`timescale 1ns/1ps
module ctrl_model
  import sr_mrr_pkg::*;
#(
  parameter int CKESR_NS = 3000
) (
  // link clock and command pins
  output logic ck_out,
  output cmd_t cmd_out
);
  logic ck_run;

  // link clock, parked only inside self refresh
  initial begin
    ck_run = 1'b1;
    ck_out = 1'b0;
    cmd_out = '{cke: 1'b1, cs_n: 1'b1, default: '0};
    #37;
    forever begin
      #(CK_PERIOD_NS / 2);
      if (ck_run) begin
        ck_out = ~ck_out;
      end
    end
  end

  task automatic drive(input logic cke, input logic cs_n,
                       input logic [9:0] r, input logic [9:0] f);
    @(posedge ck_out);
    cmd_out <= '{cke, cs_n, r, f};
  endtask

  task automatic nops(input int n, input logic cke);
    repeat (n) drive(cke, 1'b1, 10'h0, 10'h0);
  endtask

  task automatic mrr(input logic [7:0] a);
    drive(1'b1, 1'b0, {a[7:2], CMD_MRR}, {8'h0, a[1:0]});
    nops(16, 1'b1);
  endtask

  task automatic mrw(input logic [7:0] a, input logic [7:0] d);
    drive(1'b1, 1'b0, {a[7:2], CMD_MRW}, {d, a[1:0]});
    nops(4, 1'b1);
  endtask

  task automatic refresh_bank();
    drive(1'b1, 1'b0, 10'h004, 10'h0);
    nops(4, 1'b1);
  endtask

  task automatic refresh_all();
    drive(1'b1, 1'b0, 10'h00c, 10'h0);
    nops(4, 1'b1);
  endtask

  task automatic self_refresh();
    nops(1, 1'b1);
    drive(1'b0, 1'b0, {7'h0, CMD_REF_SRE}, 10'h0);
    nops(2, 1'b0);
    @(posedge ck_out);
    cmd_out <= {1'b0, 21'($urandom)};
    ck_run = 1'b0;
    #(CKESR_NS);
    ck_run = 1'b1;
    nops(3, 1'b0);
    nops(3, 1'b1);
  endtask
endmodule

// ---- tb/sr_mrr_chk.sv ----
// checker for the self refresh and mode register read ports
`timescale 1ns/1ps
module sr_mrr_chk
  import sr_mrr_pkg::*;
(
  // clocks and reset
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       ck_in,
  // pins and status
  input wire cmd_t       cmd_in,
  input wire data_bus_t  data_out,
  input wire logic       receivers_on_out,
  input wire logic [2:0] bank_ptr_out,
  input wire logic       self_refresh_out,
  input wire refresh_t   refresh_out
);
  // ------------------------
  // link clock domain
  // ------------------------
  wire logic sre_cmd = !cmd_in.cs_n && cmd_in.ca_rise[2:0] == CMD_REF_SRE;
  wire logic mrr_cmd = !cmd_in.cs_n && cmd_in.ca_rise[3:0] == CMD_MRR;

  sre_entry_a:
    assert property (@(posedge ck_in) disable iff (reset_in)
      $fell(cmd_in.cke) && sre_cmd && receivers_on_out && !data_out.dq_oe
      |-> ##2 receivers_on_out ##1 !receivers_on_out)
    else $error("self refresh entry timing wrong");
  mrr_burst_a:
    assert property (@(posedge ck_in) disable iff (reset_in)
      cmd_in.cke && $past(cmd_in.cke) && mrr_cmd && receivers_on_out
      && !data_out.dq_oe |-> ##1 !data_out.dq_oe [*8]
      ##1 data_out.dq_oe [*8] ##1 !data_out.dq_oe)
    else $error("read burst latency or length wrong");
  strobe_start_a:
    assert property (@(posedge ck_in) disable iff (reset_in)
      $rose(data_out.dqs_oe) |-> data_out.dqs == 4'hf)
    else $error("strobe burst start wrong");
  strobe_toggle_a:
    assert property (@(posedge ck_in) disable iff (reset_in)
      data_out.dqs_oe && $past(data_out.dqs_oe)
      |-> data_out.dqs == ~$past(data_out.dqs))
    else $error("strobes not toggling");
  exit_sync_a:
    assert property (@(posedge ck_in) disable iff (reset_in)
      $rose(cmd_in.cke) && !receivers_on_out
      |-> ##1 receivers_on_out && bank_ptr_out == 3'h0)
    else $error("exit did not wake or zero pointer");
  sr_quiet_a:
    assert property (@(posedge ck_in) disable iff (reset_in)
      !receivers_on_out |-> ##9 !data_out.dq_oe)
    else $error("data driven out of self refresh");
  // ------------------------
  // core clock domain
  // ------------------------
  sr_core_a:
    assert property (@(posedge clk_in) disable iff (reset_in)
      $fell(receivers_on_out) |-> ##[1:6] self_refresh_out)
    else $error("core missed self refresh entry");
  sr_core_exit_a:
    assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(receivers_on_out) |-> ##[1:6] !self_refresh_out)
    else $error("core missed self refresh exit");
  ref_in_sr_a:
    assert property (@(posedge clk_in) disable iff (reset_in)
      refresh_out.valid |-> self_refresh_out || $past(self_refresh_out))
    else $error("refresh outside self refresh");
  sweep_step_a:
    assert property (@(posedge clk_in) disable iff (reset_in)
      refresh_out.valid ##1 refresh_out.valid
      |-> refresh_out.bank == $past(refresh_out.bank) + 3'h1
      && $stable(refresh_out.row))
    else $error("sweep step wrong");

  mrr_c: cover property (@(posedge ck_in) $rose(data_out.dq_oe));
  sre_c: cover property (@(posedge ck_in) $fell(receivers_on_out));
  ref_c: cover property (@(posedge clk_in) refresh_out.valid);
endmodule

bind sr_mrr_device sr_mrr_chk u_sr_mrr_chk (
  .clk_in           (clk_in),
  .reset_in         (reset_in),
  .ck_in            (ck_in),
  .cmd_in           (cmd_in),
  .data_out         (data_out),
  .receivers_on_out (receivers_on_out),
  .bank_ptr_out     (bank_ptr_out),
  .self_refresh_out (self_refresh_out),
  .refresh_out      (refresh_out)
);

// ---- tb/tb_top.sv ----
// self checking bench for the self refresh and mode register read block
`timescale 1ns/1ps
module tb_top;
  import sr_mrr_pkg::*;
  logic        clk_in;
  logic        reset_in;
  logic        ck_in;
  cmd_t        cmd_in;
  data_bus_t   data_out;
  logic        receivers_on_out;
  logic [2:0]  bank_ptr_out;
  logic        self_refresh_out;
  refresh_t    refresh_out;
  logic [31:0] exp_q[$];
  logic [7:0]  bmask;
  logic [7:0]  smask;
  logic [7:0]  addr [6];
  int          n_mismatch;
  int          checked;
  int          n_ref;

  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  ctrl_model u_ctrl_model (.ck_out(ck_in), .cmd_out(cmd_in));
  sr_mrr_device u_sr_mrr_device (
    .clk_in           (clk_in),
    .reset_in         (reset_in),
    .ck_in            (ck_in),
    .cmd_in           (cmd_in),
    .dq_in            (32'h0),
    .dqs_in           (4'h0),
    .data_out         (data_out),
    .receivers_on_out (receivers_on_out),
    .bank_ptr_out     (bank_ptr_out),
    .self_refresh_out (self_refresh_out),
    .refresh_out      (refresh_out)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic read_mr(input logic [7:0] a);
    for (int b = 0; b < 8; b++) begin
      exp_q.push_back(a == MR_CALIB_A ? {32{PATTERN_A[b]}} :
                      a == MR_CALIB_B ? {32{PATTERN_B[b]}} : 32'h0);
    end
    u_ctrl_model.mrr(a);
  endtask

  task automatic run_sr(input logic any);
    n_ref = 0;
    u_ctrl_model.refresh_bank();
    check({29'h0, bank_ptr_out}, 32'h1);
    u_ctrl_model.self_refresh();
    check({29'h0, bank_ptr_out}, 32'h0);
    read_mr(MR_CALIB_A);
    u_ctrl_model.refresh_all();
    check({31'h0, n_ref != 0}, {31'h0, any});
  endtask

  // ------------------------
  // result watchers
  // ------------------------
  always @(posedge ck_in) begin
    if (data_out.dq_oe === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check(data_out.dq, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk_in) begin
    if (refresh_out.valid === 1'b1) begin
      n_ref++;
      check({30'h0, bmask[refresh_out.bank], smask[refresh_out.segment]},
            32'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    report_and_stop();
  end

  // ------------------------
  // main sequence
  // ------------------------
  initial begin
    n_mismatch = 0;
    checked = 0;
    n_ref = 0;
    reset_in = 1'b1;
    bmask = 8'h00;
    smask = 8'h00;
    void'($urandom(15));
    repeat (12) @(posedge clk_in);
    repeat (3) @(posedge ck_in);
    @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge ck_in);
    addr = '{MR_CALIB_A, MR_CALIB_B, MR_BANK_MASK, MR_SEG_MASK, 8'h12,
             8'($urandom)};
    foreach (addr[i]) read_mr(addr[i]);
    bmask = 8'($urandom) & 8'h7f;
    u_ctrl_model.mrw(MR_BANK_MASK, bmask);
    u_ctrl_model.mrw(MR_SEG_MASK, smask);
    u_ctrl_model.mrw(8'h12, 8'hff);
    run_sr(1'b1);
    bmask = 8'h00;
    smask = 8'hff;
    u_ctrl_model.mrw(MR_BANK_MASK, bmask);
    u_ctrl_model.mrw(MR_SEG_MASK, smask);
    run_sr(1'b0);
    repeat (4) @(posedge ck_in);
    check(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule
